// File: rtl/dspcd_consts.svh
// constants of the signal-processor execution core: offsets, opcodes, sizes
// assumes inclusion by the package and the core before use
`ifndef DSPCD_CONSTS_SVH
`define DSPCD_CONSTS_SVH

// avalon register byte offsets
`define DSPCD_AVM_AW       5
`define DSPCD_REG_CTRL     5'h00
`define DSPCD_REG_STAT     5'h04
`define DSPCD_REG_ACC      5'h08
`define DSPCD_REG_PROD     5'h0c
`define DSPCD_REG_MCAND    5'h10
`define DSPCD_REG_PLOAD    5'h14
`define DSPCD_PLOAD_ADDR_LSB 16

// sizes, reset address and interrupt vector
`define DSPCD_DRAM_WORDS   8'h90
`define DSPCD_STACK_DEPTH  4
`define DSPCD_DIV_BITS     2
`define DSPCD_PC_RST       12'h000
`define DSPCD_INT_VEC      12'h002

// opcode high bytes
`define DSPCD_OP_ADD       8'h0?
`define DSPCD_OP_SUB       8'h1?
`define DSPCD_OP_LAC       8'h2?
`define DSPCD_OP_SAR       8'b0011_000?
`define DSPCD_OP_LAR       8'b0011_100?
`define DSPCD_OP_IN        8'b0100_0???
`define DSPCD_OP_OUT       8'b0100_1???
`define DSPCD_OP_SACL      8'h50
`define DSPCD_OP_SACH      8'b0101_1???
`define DSPCD_OP_ADDH      8'h60
`define DSPCD_OP_SUBH      8'h62
`define DSPCD_OP_MAR       8'h68
`define DSPCD_OP_LT        8'h6a
`define DSPCD_OP_MPY       8'h6d
`define DSPCD_OP_LDP       8'h6f
`define DSPCD_OP_LDPTR_K   8'b0111_000?
`define DSPCD_OP_XOR       8'h78
`define DSPCD_OP_AND       8'h79
`define DSPCD_OP_OR        8'h7a
`define DSPCD_OP_LDACC_K   8'h7e
`define DSPCD_OP_MISC      8'h7f
`define DSPCD_OP_MPY_K     8'b100?_????
`define DSPCD_OP_BRANCH    8'hf?
// branch opcodes (second word holds the target)
`define DSPCD_BR_POLL      8'hf6
`define DSPCD_BR_CALL      8'hf8
`define DSPCD_BR_ALWAYS    8'hf9
`define DSPCD_BR_NEG       8'hfa
`define DSPCD_BR_NZ        8'hfe
// low bytes of the 0x7f group
`define DSPCD_MS_DINT      8'h81
`define DSPCD_MS_EINT      8'h82
`define DSPCD_MS_ZAC       8'h89
`define DSPCD_MS_RET       8'h8d
`define DSPCD_MS_PAC       8'h8e
`define DSPCD_MS_PUSH      8'h9c
`define DSPCD_MS_POP       8'h9d

`endif

// File: rtl/dspcd_pkg.sv
// types shared by the execution core and its bench
// assumes the constants header sits beside it
`include "dspcd_consts.svh"
package dspcd_pkg;
  typedef enum logic [1:0] {
    DSPCD_FETCH,
    DSPCD_FWAIT,
    DSPCD_EXEC,
    DSPCD_IO
  } dspcd_state_t;

  // indirect-mode control field of an instruction word
  typedef struct packed {
    logic inc;
    logic dec;
    logic hold;
    logic ptr;
  } dspcd_ind_t;

  // external bus outputs; drive_n low while data is driven
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
    logic        drive_n;
    logic        fetch;
    logic        din;
    logic        dout;
  } dspcd_xbus_t;
endpackage

// File: rtl/dspcd_core.sv
// fixed-point signal-processor execution core with avalon-mm control port
// assumes synchronous pins, one 125 MHz clock, external memory on a 16-bit bus
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dspcd_consts.svh"
module dspcd_core
  import dspcd_pkg::*;
#(
  parameter int PROG_AW = 6
) (
  input  wire logic                      mclk_in,
  input  wire logic                      nrst_in,
  input  wire logic [`DSPCD_AVM_AW-1:0]  avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  input  wire logic                      memory_mode_select_in,
  input  wire logic                      external_poll_n_in,
  input  wire logic                      int_req_n_in,
  input  wire logic [15:0]               shared_data_in,
  output dspcd_xbus_t                    xbus_out,
  output logic                           divided_clock_out
);

  if (PROG_AW < 1 || PROG_AW > 12) begin : g_chk
    $error("PROG_AW must lie in 1..12");
  end

  localparam int PWORDS = 1 << PROG_AW;

  dspcd_state_t state_reg;
  dspcd_xbus_t  xbus_reg;
  dspcd_ind_t   ind;
  logic [15:0]  ram [0:`DSPCD_DRAM_WORDS-1];
  logic [15:0]  prog [0:PWORDS-1];
  logic [11:0]  stk_reg [0:`DSPCD_STACK_DEPTH-1];
  logic [11:0]  stk_push_src [0:`DSPCD_STACK_DEPTH-1];
  logic [11:0]  stk_pop_src [0:`DSPCD_STACK_DEPTH-1];
  logic [15:0]  ar_reg [0:1];
  logic [31:0]  acc_reg;
  logic [31:0]  p_reg;
  logic [15:0]  t_reg;
  logic [15:0]  ir_reg;
  logic [11:0]  pc_reg;
  logic         dp_reg;
  logic         arp_reg;
  logic         intm_reg;
  logic         br_reg;
  logic         run_reg;
  logic         mc_reg;
  logic         poll_n_reg;
  logic         int_n_reg;
  logic         io_in_reg;
  logic [7:0]   io_addr_reg;
  logic         wait_reg;
  logic [31:0]  rdata_reg;
  logic [`DSPCD_DIV_BITS-1:0] div_cnt_reg;
  logic         div_reg;

  logic [7:0]   op;
  logic [7:0]   daddr;
  logic         d_ok;
  logic [15:0]  opnd;
  logic [31:0]  shin;
  logic [31:0]  sach;
  logic [31:0]  prod;
  logic [15:0]  kfac;
  logic         is_mem;
  logic         int_take;
  logic         consume;
  logic [15:0]  word;
  logic         br_take;
  logic         stk_push;
  logic         stk_pop;
  logic [11:0]  stk_val;
  logic         ram_we;
  logic [7:0]   ram_wa;
  logic [15:0]  ram_wd;
  logic [31:0]  rd_mux;

  assign op = ir_reg[15:8];

  // pins are synchronous, one flop each
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mc_reg     <= 1'b0;
      poll_n_reg <= 1'b1;
      int_n_reg  <= 1'b1;
    end else begin
      mc_reg     <= memory_mode_select_in;
      poll_n_reg <= external_poll_n_in;
      int_n_reg  <= int_req_n_in;
    end
  end

  // divider: bit 1 of a free counter has a four-cycle period
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_reg <= '0;
      div_reg     <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
      div_reg     <= div_cnt_reg[1];
    end
  end

  // operand path
  always_comb begin
    ind   = '{inc: ir_reg[5], dec: ir_reg[4], hold: ir_reg[3], ptr: ir_reg[0]};
    daddr = ir_reg[7] ? ar_reg[arp_reg][7:0] : {dp_reg, ir_reg[6:0]};
    d_ok  = daddr < `DSPCD_DRAM_WORDS;
    opnd  = d_ok ? ram[daddr] : 16'h0000;
    shin  = {{16{opnd[15]}}, opnd} << ir_reg[11:8];
    unique case (ir_reg[10:8])
      3'h1:    sach = acc_reg << 1;
      3'h4:    sach = acc_reg << 4;
      default: sach = acc_reg;
    endcase
    kfac  = {{3{ir_reg[12]}}, ir_reg[12:0]};
    // product sized by its 32-bit target; a cast here would keep only 16 bits
    prod  = $signed(t_reg) * $signed(op[7] ? kfac : opnd);
    is_mem = !op[7] && (op[6:4] != 3'h7 || op == 8'h78 || op == 8'h79 || op == 8'h7a);
  end

  // fetch and branch decisions
  always_comb begin
    int_take = state_reg == DSPCD_FETCH && run_reg && !br_reg && !int_n_reg
               && !intm_reg;
    consume  = run_reg && !int_take
               && ((state_reg == DSPCD_FETCH && mc_reg) || state_reg == DSPCD_FWAIT);
    word     = mc_reg ? prog[pc_reg[PROG_AW-1:0]] : shared_data_in;
    unique case (op)
      `DSPCD_BR_POLL:   br_take = !poll_n_reg;
      `DSPCD_BR_CALL:   br_take = 1'b1;
      `DSPCD_BR_ALWAYS: br_take = 1'b1;
      `DSPCD_BR_NEG:    br_take = acc_reg[31];
      `DSPCD_BR_NZ:     br_take = acc_reg != 32'h0000_0000;
      default:          br_take = 1'b0;
    endcase
    stk_push = int_take || (consume && br_reg && op == `DSPCD_BR_CALL)
               || (state_reg == DSPCD_EXEC && op == `DSPCD_OP_MISC
                   && ir_reg[7:0] == `DSPCD_MS_PUSH);
    stk_pop  = state_reg == DSPCD_EXEC && op == `DSPCD_OP_MISC
               && (ir_reg[7:0] == `DSPCD_MS_RET || ir_reg[7:0] == `DSPCD_MS_POP);
    if (int_take) begin
      stk_val = pc_reg;
    end else if (state_reg == DSPCD_EXEC) begin
      stk_val = acc_reg[11:0];
    end else begin
      stk_val = 12'(pc_reg + 12'h001);  // return lands past the target word
    end
  end

  // data memory writes: stores and port input
  always_comb begin
    ram_we = 1'b0;
    ram_wa = daddr;
    ram_wd = acc_reg[15:0];
    if (state_reg == DSPCD_IO && io_in_reg) begin
      ram_we = io_addr_reg < `DSPCD_DRAM_WORDS;
      ram_wa = io_addr_reg;
      ram_wd = shared_data_in;
    end else if (state_reg == DSPCD_EXEC && d_ok) begin
      casez (op)
        `DSPCD_OP_SACL: ram_we = 1'b1;
        `DSPCD_OP_SACH: begin
          ram_we = 1'b1;
          ram_wd = sach[31:16];
        end
        `DSPCD_OP_SAR: begin
          ram_we = 1'b1;
          ram_wd = ar_reg[ir_reg[8]];
        end
        default: ram_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  // return stack, one generate entry per level
  for (genvar i = 0; i < `DSPCD_STACK_DEPTH; i++) begin : g_stk
    if (i == 0) begin : g_top
      assign stk_push_src[i] = stk_val;
    end else begin : g_mid
      assign stk_push_src[i] = stk_reg[i-1];
    end
    if (i == `DSPCD_STACK_DEPTH - 1) begin : g_bot
      assign stk_pop_src[i] = stk_reg[i];  // deepest level is copied, not lost
    end else begin : g_up
      assign stk_pop_src[i] = stk_reg[i+1];
    end
    always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        stk_reg[i] <= 12'h000;
      end else if (stk_push) begin
        stk_reg[i] <= stk_push_src[i];
      end else if (stk_pop) begin
        stk_reg[i] <= stk_pop_src[i];
      end
    end
  end

  // sequencer and datapath registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg   <= DSPCD_FETCH;
      xbus_reg    <= '{addr: 12'h000, data: 16'h0000, drive_n: 1'b1,
                       fetch: 1'b0, din: 1'b0, dout: 1'b0};
      ir_reg      <= 16'h0000;
      pc_reg      <= `DSPCD_PC_RST;
      acc_reg     <= 32'h0000_0000;
      p_reg       <= 32'h0000_0000;
      t_reg       <= 16'h0000;
      ar_reg[0]   <= 16'h0000;
      ar_reg[1]   <= 16'h0000;
      dp_reg      <= 1'b0;
      arp_reg     <= 1'b0;
      intm_reg    <= 1'b1;
      br_reg      <= 1'b0;
      io_in_reg   <= 1'b0;
      io_addr_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        DSPCD_FETCH: begin
          if (int_take) begin
            pc_reg   <= `DSPCD_INT_VEC;
            intm_reg <= 1'b1;
          end else if (run_reg && !mc_reg) begin
            xbus_reg.addr  <= pc_reg;
            xbus_reg.fetch <= 1'b1;
            state_reg      <= DSPCD_FWAIT;
          end
        end
        DSPCD_FWAIT: begin
          xbus_reg.fetch <= 1'b0;
        end
        DSPCD_EXEC: begin
          state_reg <= DSPCD_FETCH;
          if (ir_reg[7] && is_mem) begin
            if (ind.inc) begin
              ar_reg[arp_reg] <= ar_reg[arp_reg] + 16'h0001;
            end else if (ind.dec) begin
              ar_reg[arp_reg] <= ar_reg[arp_reg] - 16'h0001;
            end
            if (!ind.hold) begin
              arp_reg <= ind.ptr;
            end
          end
          casez (op)
            `DSPCD_OP_ADD:  acc_reg <= acc_reg + shin;
            `DSPCD_OP_SUB:  acc_reg <= acc_reg - shin;
            `DSPCD_OP_LAC:  acc_reg <= shin;
            `DSPCD_OP_ADDH: acc_reg <= acc_reg + {opnd, 16'h0000};
            `DSPCD_OP_SUBH: acc_reg <= acc_reg - {opnd, 16'h0000};
            `DSPCD_OP_XOR:  acc_reg <= acc_reg ^ {16'h0000, opnd};
            `DSPCD_OP_AND:  acc_reg <= acc_reg & {16'h0000, opnd};
            `DSPCD_OP_OR:   acc_reg <= acc_reg | {16'h0000, opnd};
            `DSPCD_OP_LDACC_K: acc_reg <= {24'h00_0000, ir_reg[7:0]};
            `DSPCD_OP_LAR:  ar_reg[ir_reg[8]] <= opnd;
            `DSPCD_OP_LDPTR_K: ar_reg[ir_reg[8]] <= {8'h00, ir_reg[7:0]};
            `DSPCD_OP_LDP:  dp_reg <= opnd[0];
            `DSPCD_OP_LT:   t_reg <= opnd;
            `DSPCD_OP_MPY:  p_reg <= prod;
            `DSPCD_OP_MPY_K: p_reg <= prod;
            `DSPCD_OP_IN, `DSPCD_OP_OUT: begin
              xbus_reg.addr <= {9'h000, ir_reg[10:8]};
              io_addr_reg   <= daddr;
              io_in_reg     <= !ir_reg[11];
              xbus_reg.din  <= !ir_reg[11];
              xbus_reg.dout <= ir_reg[11];
              xbus_reg.drive_n <= !ir_reg[11];
              xbus_reg.data <= opnd;
              state_reg     <= DSPCD_IO;
            end
            `DSPCD_OP_BRANCH: br_reg <= 1'b1;
            `DSPCD_OP_MISC: begin
              unique case (ir_reg[7:0])
                `DSPCD_MS_DINT: intm_reg <= 1'b1;
                `DSPCD_MS_EINT: intm_reg <= 1'b0;
                `DSPCD_MS_ZAC:  acc_reg <= 32'h0000_0000;
                `DSPCD_MS_PAC:  acc_reg <= p_reg;
                `DSPCD_MS_RET:  pc_reg <= stk_reg[0];
                `DSPCD_MS_POP:  acc_reg <= {20'h0_0000, stk_reg[0]};
                default: acc_reg <= acc_reg;  // unknown codes act as no-ops
              endcase
            end
            default: acc_reg <= acc_reg;
          endcase
        end
        DSPCD_IO: begin
          // strobes last exactly one cycle; bus released with them
          xbus_reg.din     <= 1'b0;
          xbus_reg.dout    <= 1'b0;
          xbus_reg.drive_n <= 1'b1;
          io_in_reg        <= 1'b0;
          state_reg        <= DSPCD_FETCH;
        end
      endcase
      if (consume) begin
        state_reg <= br_reg ? DSPCD_FETCH : DSPCD_EXEC;
        br_reg    <= 1'b0;
        if (br_reg) begin
          pc_reg <= br_take ? word[11:0] : 12'(pc_reg + 12'h001);
        end else begin
          ir_reg <= word;
          pc_reg <= 12'(pc_reg + 12'h001);
        end
      end
    end
  end

  // avalon read mux; unmapped offsets read zero
  always_comb begin
    unique case (avs_address_in)
      `DSPCD_REG_CTRL:  rd_mux = {31'h0000_0000, run_reg};
      `DSPCD_REG_STAT:  rd_mux = {12'h000, br_reg, 2'(state_reg), poll_n_reg, mc_reg,
                                  intm_reg, arp_reg, dp_reg, pc_reg};
      `DSPCD_REG_ACC:   rd_mux = acc_reg;
      `DSPCD_REG_PROD:  rd_mux = p_reg;
      `DSPCD_REG_MCAND: rd_mux = {16'h0000, t_reg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // waitrequest drops one cycle after a request; the access lands then
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      run_reg   <= 1'b0;
    end else begin
      wait_reg <= !((avs_read_in || avs_write_in) && wait_reg);
      if (avs_read_in && wait_reg) begin
        rdata_reg <= rd_mux;
      end
      if (avs_write_in && !wait_reg && avs_address_in == `DSPCD_REG_CTRL) begin
        run_reg <= avs_writedata_in[0];
      end
    end
  end

  // program store load port; no reset so it maps to block memory
  always_ff @(posedge mclk_in) begin
    if (avs_write_in && !wait_reg && avs_address_in == `DSPCD_REG_PLOAD) begin
      prog[avs_writedata_in[`DSPCD_PLOAD_ADDR_LSB +: PROG_AW]] <= avs_writedata_in[15:0];
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign xbus_out            = xbus_reg;
  assign divided_clock_out   = div_reg;

endmodule

// File: testbench/dspcd_core_asserts.sv
// concurrent checks on the core's bus strobes, clock output and control handshake
// assumes binding to the core; every output it watches is registered on mclk_in
`timescale 1ns/1ps
module dspcd_core_asserts
  import dspcd_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        memory_mode_select_in,
  input wire dspcd_xbus_t xbus_out,
  input wire logic        divided_clock_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_clk_quarter: assert property ($rose(divided_clock_out) |=>
    divided_clock_out ##1 !divided_clock_out [*2] ##1 divided_clock_out)
    else $error("divided clock is not a quarter of the input clock");
  a_mode_nofetch: assert property (memory_mode_select_in [*4] |-> !xbus_out.fetch)
    else $error("fetch strobe seen while running from the internal store");
  a_fetch_single: assert property (xbus_out.fetch |=> !xbus_out.fetch)
    else $error("fetch strobe longer than one cycle");
  a_in_quiet: assert property (
    xbus_out.din |-> xbus_out.drive_n && !xbus_out.fetch && !xbus_out.dout)
    else $error("core drives or fetches while accepting input");
  a_in_single: assert property (xbus_out.din |=> !xbus_out.din)
    else $error("input strobe longer than one cycle");
  a_out_drive: assert property (xbus_out.dout == !xbus_out.drive_n)
    else $error("output strobe and data drive disagree");
  a_out_single: assert property (xbus_out.dout |=> !xbus_out.dout)
    else $error("output strobe longer than one cycle");
  a_io_port: assert property (
    (xbus_out.din || xbus_out.dout) |-> xbus_out.addr[11:3] == 9'h000)
    else $error("port number not confined to the low address lines");
  a_wait_single: assert property (
    $rose(avs_read_in) || $rose(avs_write_in) |=> !avs_waitrequest_out)
    else $error("control port did not answer after one wait cycle");
  a_wait_idle: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("waitrequest low with no request pending");
  a_wait_pulse: assert property ($fell(avs_waitrequest_out) |=> $rose(avs_waitrequest_out))
    else $error("waitrequest low for more than one cycle");

  c_port_out: cover property (xbus_out.dout);
  c_port_in: cover property (xbus_out.din);
  c_reg_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule

bind dspcd_core dspcd_core_asserts dspcd_core_asserts_i (
  .mclk_in               (mclk_in),
  .nrst_in               (nrst_in),
  .avs_read_in           (avs_read_in),
  .avs_write_in          (avs_write_in),
  .avs_waitrequest_out   (avs_waitrequest_out),
  .memory_mode_select_in (memory_mode_select_in),
  .xbus_out              (xbus_out),
  .divided_clock_out     (divided_clock_out)
);

// File: testbench/dspcd_mem_model.sv
// external program memory and port devices on the shared data bus
// assumes one-cycle registered strobes; the bench fills prog and port_in
`timescale 1ns/1ps
module dspcd_mem_model
  import dspcd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire dspcd_xbus_t xbus_in,
  output logic [15:0]      shared_data_out
);
  logic [15:0] prog[0:63];
  logic [15:0] port_in[0:7];
  logic [15:0] idle_reg = 16'h0000;

  // a released bus wanders each cycle so a stale word never reads as good
  always_ff @(posedge mclk_in) begin
    idle_reg <= idle_reg + 16'h3b1d;
  end

  always_comb begin
    if (xbus_in.fetch) begin
      shared_data_out = prog[xbus_in.addr[5:0]];
    end else if (xbus_in.din) begin
      shared_data_out = port_in[xbus_in.addr[2:0]];
    end else begin
      shared_data_out = idle_reg;
    end
  end
endmodule

// File: testbench/tb_dspcd_core.sv
// bench for the execution core: one program from the bus model, one from the
// internal store; port writes and register reads are checked from queues
// assumes the package, header and bus model are compiled first
`timescale 1ns/1ps
`include "dspcd_consts.svh"
module tb_dspcd_core
  import dspcd_pkg::*;
;
  logic                     mclk_in;
  logic                     nrst_in;
  logic [`DSPCD_AVM_AW-1:0] avs_address_in;
  logic                     avs_read_in;
  logic                     avs_write_in;
  logic [31:0]              avs_writedata_in;
  logic [31:0]              avs_readdata_out;
  logic                     avs_waitrequest_out;
  logic                     memory_mode_select_in;
  logic                     external_poll_n_in;
  logic                     int_req_n_in;
  logic [15:0]              shared_data_in;
  dspcd_xbus_t              xbus_out;
  logic                     divided_clock_out;
  int                       err_count = 0;
  int                       tests_run = 0;
  int                       cyc = 0;
  logic [31:0]              exp_rd[$];
  logic [27:0]              exp_out[$];
  logic [15:0]              pin;
  logic [7:0]               k;

  // reserved bits 6, 2 and 1 of every indirect word are kept zero
  localparam logic [15:0] PROG_EXT[20] = '{
    16'h7e01, 16'h5010, 16'h6f10, 16'h5003, 16'h4803, 16'h4205, 16'h2405, 16'h6a05,
    16'h8003, 16'h7105, 16'h7004, 16'h6881, 16'h5988, 16'h4d98, 16'h5090, 16'h4980,
    16'h4ea0, 16'h4f80, 16'hf900, 16'h0012};

  dspcd_core #(.PROG_AW(6)) dspcd_core_i (
    .mclk_in               (mclk_in),
    .nrst_in               (nrst_in),
    .avs_address_in        (avs_address_in),
    .avs_read_in           (avs_read_in),
    .avs_write_in          (avs_write_in),
    .avs_writedata_in      (avs_writedata_in),
    .avs_readdata_out      (avs_readdata_out),
    .avs_waitrequest_out   (avs_waitrequest_out),
    .memory_mode_select_in (memory_mode_select_in),
    .external_poll_n_in    (external_poll_n_in),
    .int_req_n_in          (int_req_n_in),
    .shared_data_in        (shared_data_in),
    .xbus_out              (xbus_out),
    .divided_clock_out     (divided_clock_out)
  );

  dspcd_mem_model dspcd_mem_model_i (
    .mclk_in         (mclk_in),
    .xbus_in         (xbus_out),
    .shared_data_out (shared_data_in)
  );

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL readdata expected %h seen %h", e, g);
    end
  endtask

  task automatic check_out(input logic [27:0] e, input logic [27:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL port_out expected %h seen %h", e, g);
    end
  endtask

  // one edge always passes before a new request, so no signal is set twice
  task automatic av_cycle(input logic [`DSPCD_AVM_AW-1:0] a, input logic wr,
                          input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do
      @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic av_rd(input logic [`DSPCD_AVM_AW-1:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    av_cycle(a, 1'b0, 32'h0000_0000);
  endtask

  always @(posedge mclk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
      check_reg(exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hxxxx_xxxx, avs_readdata_out);
    if (xbus_out.dout === 1'b1)
      check_out(exp_out.size() > 0 ? exp_out.pop_front() : 28'hxxx_xxxx,
                {xbus_out.addr, xbus_out.data});
  end

  // both programs settle within a few hundred cycles
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    logic [15:0]        w[11];
    logic [31:0]        a;
    logic signed [31:0] p;
    nrst_in               = 1'b0;
    avs_address_in        = '0;
    avs_read_in           = 1'b0;
    avs_write_in          = 1'b0;
    avs_writedata_in      = 32'h0000_0000;
    memory_mode_select_in = 1'b0;
    external_poll_n_in    = 1'b1;
    int_req_n_in          = 1'b0;  // held low but masked throughout
    void'($urandom(32'h0000_a2b9));
    pin = 16'($urandom);
    k = 8'($urandom);
    for (int i = 0; i < 20; i++)
      dspcd_mem_model_i.prog[i] = PROG_EXT[i];
    dspcd_mem_model_i.port_in[2] = pin;
    a = {{12{pin[15]}}, pin, 4'h0};
    p = $signed({{16{pin[15]}}, pin}) * 32'sd3;
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    exp_out.push_back({12'h000, 16'h0001});
    exp_out.push_back({12'h005, a[30:15]});
    exp_out.push_back({12'h001, a[15:0]});
    exp_out.push_back({12'h006, a[15:0]});
    exp_out.push_back({12'h007, a[30:15]});
    av_wr_run: av_cycle(5'h00, 1'b1, 32'h0000_0001);
    for (int n = 0; n < 400 && exp_out.size() > 0; n++)
      @(posedge mclk_in);
    check_out(28'h000_0000, 28'(exp_out.size()));
    av_rd(5'h08, a);
    av_rd(5'h0c, p);
    av_rd(5'h10, {16'h0000, pin});
    av_cycle(5'h08, 1'b1, 32'h1234_5678);
    av_rd(5'h08, a);
    av_rd(5'h1c, 32'h0000_0000);
    // stop, reset while stopped and rerun from the internal store
    av_cycle(5'h00, 1'b1, 32'h0000_0000);
    memory_mode_select_in <= 1'b1;
    nrst_in <= 1'b0;
    @(posedge mclk_in);
    nrst_in <= 1'b1;
    // the add sits after a call whose subroutine only returns
    w = '{{8'h7e, k}, 16'h5020, 16'h7e0f, 16'h7920, 16'h7820, 16'hf800, 16'h000a,
          16'h0020, 16'hf900, 16'h0008, 16'h7f8d};
    for (int i = 0; i < 11; i++)
      av_cycle(5'h14, 1'b1, {10'h000, 6'(i), w[i]});
    av_cycle(5'h00, 1'b1, 32'h0000_0001);
    repeat (100) @(posedge mclk_in);
    av_rd(5'h08, 32'(k & 8'hf0) + 32'(k));
    @(posedge mclk_in);
    stop_test();
  end
endmodule
